// [i2cc_cfg.svh]
// Timing and field constants shared by both ends of the two-wire link
`ifndef I2CC_CFG_SVH
`define I2CC_CFG_SVH
`define I2CC_CLK_KHZ          250000
`define I2CC_SMB_TIMEOUT_MS   35
`define I2CC_STRETCH_MARGIN_MS 1
`define I2CC_SMB_SCL_MIN_KHZ  10
`define I2CC_SMB_SCL_MAX_KHZ  100
`define I2CC_STD_SCL_MAX_KHZ  100
`define I2CC_SCL_KHZ          100
`define I2CC_QUARTERS         4
`define I2CC_LEGACY_ADDR      7'h01
`define I2CC_BYTE_BITS        4'h8
`define I2CC_ACK_BITS         4'h9
`define I2CC_READ_FILL        8'hFF
`endif

// [i2cc_pkg.sv]
// Types shared by both ends of the two-wire link
`default_nettype none
package i2cc_pkg;
	typedef enum logic [1:0] {
		I2CC_CMD_START,
		I2CC_CMD_WRITE,
		I2CC_CMD_READ,
		I2CC_CMD_STOP
	} i2cc_cmd_t;

	typedef enum logic [2:0] {
		TGT_IDLE,
		TGT_ADDR,
		TGT_ACK_ADDR,
		TGT_WR,
		TGT_ACK_WR,
		TGT_RD,
		TGT_ACK_RD,
		TGT_SKIP
	} i2cc_tgt_state_t;

	typedef enum logic [1:0] {
		CTL_IDLE,
		CTL_START,
		CTL_BITS,
		CTL_STOP
	} i2cc_ctl_state_t;
endpackage : i2cc_pkg
`default_nettype wire

// [i2cc_bus_if.sv]
// Open-drain bus wires and legacy enable line between controller and target
`default_nettype none
interface i2cc_bus_if;
	logic ctl_scl_o;
	logic ctl_scl_oe;
	logic ctl_sda_o;
	logic ctl_sda_oe;
	logic tgt_scl_o;
	logic tgt_scl_oe;
	logic tgt_sda_o;
	logic tgt_sda_oe;
	logic legacy_data_enable;
	logic scl;
	logic sda;

	// Wired-AND with pull-up: any enabled low driver pulls the line down
	assign scl = ~((ctl_scl_oe & ~ctl_scl_o) | (tgt_scl_oe & ~tgt_scl_o));
	assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (tgt_sda_oe & ~tgt_sda_o));

	modport ctl (
		output ctl_scl_o, ctl_scl_oe, ctl_sda_o, ctl_sda_oe, legacy_data_enable,
		input  scl, sda
	);
	modport tgt (
		output tgt_scl_o, tgt_scl_oe, tgt_sda_o, tgt_sda_oe,
		input  scl, sda, legacy_data_enable
	);
endinterface : i2cc_bus_if
`default_nettype wire

// [i2cc_target.sv]
// Two-wire bus target with legacy-address rejection and management timeout
`include "i2cc_cfg.svh"
`default_nettype none
module i2cc_target #(
	parameter int TIMEOUT_CYC = `I2CC_SMB_TIMEOUT_MS * `I2CC_CLK_KHZ,
	parameter int STRETCH_CYC = (`I2CC_SMB_TIMEOUT_MS - `I2CC_STRETCH_MARGIN_MS) * `I2CC_CLK_KHZ
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Bus side
	i2cc_bus_if.tgt         bus,
	// Configuration
	input  wire logic [6:0] own_addr,
	input  wire logic       smbus_mode,
	// Local data side
	input  wire logic       busy,
	input  wire logic [7:0] tx_data,
	output logic            tx_taken,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	// Timeout event
	input  wire logic       timeout_clr,
	output logic            timeout_flag
);
	if (STRETCH_CYC < 1 || STRETCH_CYC >= TIMEOUT_CYC) begin : g_chk
		$error("i2cc_target: stretch limit must lie below the timeout");
	end

	logic                     scl_m_r, scl_s_r, scl_d_r;
	logic                     sda_m_r, sda_s_r, sda_d_r;
	i2cc_pkg::i2cc_tgt_state_t state_r, state_nxt;
	logic                     legacy_r, legacy_nxt;
	logic [3:0]               bit_r, bit_nxt;
	logic [7:0]               shift_r, shift_nxt;
	logic                     rw_r, rw_nxt;
	logic                     sda_oe_r, sda_oe_nxt;
	logic                     hold_r, hold_nxt;
	logic [31:0]              low_cnt_r, low_cnt_nxt;
	logic [31:0]              xfer_cnt_r, xfer_cnt_nxt;
	logic [7:0]               rx_data_r, rx_data_nxt;
	logic                     rx_valid_r, rx_valid_nxt;
	logic                     tx_taken_r, tx_taken_nxt;
	logic                     to_flag_r, to_flag_nxt;
	logic                     rise, fall, start_c, stop_c;
	logic                     timeout, stretch_lim, hold_end;

	// Bus lines come from outside the clock domain
	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_m_r <= bus.scl;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= bus.sda;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	assign rise    = scl_s_r & ~scl_d_r;
	assign fall    = ~scl_s_r & scl_d_r;
	assign start_c = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign stop_c  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	// Counters only run in management mode; plain mode has no time limit
	assign timeout     = smbus_mode & ((low_cnt_r >= 32'(TIMEOUT_CYC)) | (xfer_cnt_r >= 32'(TIMEOUT_CYC)));
	assign stretch_lim = smbus_mode & (low_cnt_r >= 32'(STRETCH_CYC));
	assign hold_end    = hold_r & (~busy | stretch_lim);

	always_comb begin
		state_nxt    = state_r;
		legacy_nxt   = legacy_r;
		bit_nxt      = bit_r;
		shift_nxt    = shift_r;
		rw_nxt       = rw_r;
		sda_oe_nxt   = sda_oe_r;
		hold_nxt     = hold_r & ~hold_end;
		rx_data_nxt  = rx_data_r;
		rx_valid_nxt = 1'b0;
		tx_taken_nxt = 1'b0;
		low_cnt_nxt  = 32'h0;
		xfer_cnt_nxt = 32'h0;
		to_flag_nxt  = to_flag_r & ~timeout_clr;
		if (smbus_mode && state_r != i2cc_pkg::TGT_IDLE) begin
			low_cnt_nxt  = scl_s_r ? 32'h0 : 32'(low_cnt_r + 32'h1);
			xfer_cnt_nxt = 32'(xfer_cnt_r + 32'h1);
		end
		if (timeout) begin
			state_nxt   = i2cc_pkg::TGT_IDLE;
			legacy_nxt  = 1'b0;
			sda_oe_nxt  = 1'b0;
			hold_nxt    = 1'b0;
			to_flag_nxt = 1'b1;
		end else if (stop_c) begin
			state_nxt  = i2cc_pkg::TGT_IDLE;
			legacy_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
			hold_nxt   = 1'b0;
		end else if (start_c && !legacy_r) begin
			state_nxt  = i2cc_pkg::TGT_ADDR;
			bit_nxt    = 4'h0;
			sda_oe_nxt = 1'b0;
			hold_nxt   = 1'b0;
		end else begin
			case (state_r)
				i2cc_pkg::TGT_ADDR: begin
					if (rise) begin
						shift_nxt = {shift_r[6:0], sda_s_r};
						bit_nxt   = 4'(bit_r + 4'h1);
					end
					if (fall && bit_r == `I2CC_BYTE_BITS) begin
						if (shift_r[7:1] == `I2CC_LEGACY_ADDR) begin
							state_nxt  = i2cc_pkg::TGT_SKIP;
							legacy_nxt = 1'b1;
						end else if (shift_r[7:1] == own_addr) begin
							state_nxt  = i2cc_pkg::TGT_ACK_ADDR;
							rw_nxt     = shift_r[0];
							sda_oe_nxt = 1'b1;
						end else begin
							state_nxt = i2cc_pkg::TGT_SKIP;
						end
					end
				end
				i2cc_pkg::TGT_ACK_ADDR, i2cc_pkg::TGT_ACK_WR: begin
					if (fall) begin
						sda_oe_nxt = 1'b0;
						bit_nxt    = 4'h0;
						hold_nxt   = 1'b1;
						state_nxt  = (state_r == i2cc_pkg::TGT_ACK_ADDR && rw_r) ?
						             i2cc_pkg::TGT_RD : i2cc_pkg::TGT_WR;
					end
				end
				i2cc_pkg::TGT_WR: begin
					if (rise) begin
						shift_nxt = {shift_r[6:0], sda_s_r};
						bit_nxt   = 4'(bit_r + 4'h1);
					end
					if (fall && bit_r == `I2CC_BYTE_BITS) begin
						rx_data_nxt  = shift_r;
						rx_valid_nxt = 1'b1;
						sda_oe_nxt   = 1'b1;
						state_nxt    = i2cc_pkg::TGT_ACK_WR;
					end
				end
				i2cc_pkg::TGT_RD: begin
					if (hold_r) begin
						shift_nxt    = tx_data;
						sda_oe_nxt   = ~tx_data[7];
						tx_taken_nxt = hold_end;
					end else begin
						if (rise) begin
							bit_nxt = 4'(bit_r + 4'h1);
						end
						if (fall) begin
							if (bit_r == `I2CC_BYTE_BITS) begin
								sda_oe_nxt = 1'b0;
								state_nxt  = i2cc_pkg::TGT_ACK_RD;
							end else begin
								shift_nxt  = {shift_r[6:0], 1'b0};
								sda_oe_nxt = ~shift_r[6];
							end
						end
					end
				end
				i2cc_pkg::TGT_ACK_RD: begin
					if (rise && sda_s_r) begin
						state_nxt = i2cc_pkg::TGT_SKIP;
					end else if (fall) begin
						bit_nxt   = 4'h0;
						hold_nxt  = 1'b1;
						state_nxt = i2cc_pkg::TGT_RD;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r    <= i2cc_pkg::TGT_IDLE;
			legacy_r   <= 1'b0;
			bit_r      <= 4'h0;
			shift_r    <= 8'h00;
			rw_r       <= 1'b0;
			sda_oe_r   <= 1'b0;
			hold_r     <= 1'b0;
			low_cnt_r  <= 32'h0;
			xfer_cnt_r <= 32'h0;
			rx_data_r  <= 8'h00;
			rx_valid_r <= 1'b0;
			tx_taken_r <= 1'b0;
			to_flag_r  <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			legacy_r   <= legacy_nxt;
			bit_r      <= bit_nxt;
			shift_r    <= shift_nxt;
			rw_r       <= rw_nxt;
			sda_oe_r   <= sda_oe_nxt;
			hold_r     <= hold_nxt;
			low_cnt_r  <= low_cnt_nxt;
			xfer_cnt_r <= xfer_cnt_nxt;
			rx_data_r  <= rx_data_nxt;
			rx_valid_r <= rx_valid_nxt;
			tx_taken_r <= tx_taken_nxt;
			to_flag_r  <= to_flag_nxt;
		end
	end

	assign bus.tgt_scl_o  = 1'b0;
	assign bus.tgt_scl_oe = hold_r;
	assign bus.tgt_sda_o  = 1'b0;
	assign bus.tgt_sda_oe = sda_oe_r;
	assign rx_data        = rx_data_r;
	assign rx_valid       = rx_valid_r;
	assign tx_taken       = tx_taken_r;
	assign timeout_flag   = to_flag_r;
endmodule : i2cc_target
`default_nettype wire

// [i2cc_controller.sv]
// Two-wire bus controller with legacy-frame support and clock-rate check
`include "i2cc_cfg.svh"
`default_nettype none
module i2cc_controller #(
	parameter int SCL_KHZ = `I2CC_SCL_KHZ,
	parameter bit SMBUS   = 1'b1
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Bus side
	i2cc_bus_if.ctl                bus,
	// Command side
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire i2cc_pkg::i2cc_cmd_t cmd,
	input  wire logic [7:0]        cmd_data,
	input  wire logic              cmd_nack,
	input  wire logic              cmd_legacy,
	// Response side
	output logic                   rsp_valid,
	output logic [7:0]             rsp_data,
	output logic                   rsp_nack,
	output logic                   cmd_refused
);
	localparam int QTR_CYC = `I2CC_CLK_KHZ / (`I2CC_QUARTERS * SCL_KHZ);

	if (SCL_KHZ > `I2CC_STD_SCL_MAX_KHZ || QTR_CYC < 1 ||
	    (SMBUS && (SCL_KHZ < `I2CC_SMB_SCL_MIN_KHZ || SCL_KHZ > `I2CC_SMB_SCL_MAX_KHZ))) begin : g_chk
		$error("i2cc_controller: clock rate out of range");
	end

	logic                      scl_m_r, scl_s_r, sda_m_r, sda_s_r;
	i2cc_pkg::i2cc_ctl_state_t state_r, state_nxt;
	logic [1:0]                phase_r, phase_nxt;
	logic [31:0]               qcnt_r, qcnt_nxt;
	logic [3:0]                bits_r, bits_nxt;
	logic [8:0]                tx_r, tx_nxt, rx_r, rx_nxt;
	logic                      scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
	logic                      first_r, first_nxt, armed_r, armed_nxt;
	logic                      leg_en_r, leg_en_nxt, leg_frame_r, leg_frame_nxt;
	logic                      rsp_valid_r, rsp_valid_nxt, rsp_nack_r, rsp_nack_nxt;
	logic [7:0]                rsp_data_r, rsp_data_nxt;
	logic                      refused_r, refused_nxt;
	logic                      tick, go;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
		end else begin
			scl_m_r <= bus.scl;
			scl_s_r <= scl_m_r;
			sda_m_r <= bus.sda;
			sda_s_r <= sda_m_r;
		end
	end

	assign tick      = (qcnt_r == 32'(QTR_CYC - 1));
	// Third quarter waits for the released clock to read high, so target stretching holds the bit
	assign go        = tick & ((phase_r != 2'h2) | scl_s_r);
	assign cmd_ready = (state_r == i2cc_pkg::CTL_IDLE);

	always_comb begin
		state_nxt     = state_r;
		phase_nxt     = phase_r;
		qcnt_nxt      = 32'h0;
		bits_nxt      = bits_r;
		tx_nxt        = tx_r;
		rx_nxt        = rx_r;
		scl_oe_nxt    = scl_oe_r;
		sda_oe_nxt    = sda_oe_r;
		first_nxt     = first_r;
		armed_nxt     = armed_r;
		leg_en_nxt    = leg_en_r;
		leg_frame_nxt = leg_frame_r;
		rsp_valid_nxt = 1'b0;
		rsp_data_nxt  = rsp_data_r;
		rsp_nack_nxt  = rsp_nack_r;
		refused_nxt   = 1'b0;
		if (state_r == i2cc_pkg::CTL_IDLE) begin
			phase_nxt = 2'h0;
			if (cmd_valid) begin
				case (cmd)
					i2cc_pkg::I2CC_CMD_START: begin
						state_nxt = i2cc_pkg::CTL_START;
					end
					i2cc_pkg::I2CC_CMD_STOP: begin
						state_nxt = i2cc_pkg::CTL_STOP;
					end
					i2cc_pkg::I2CC_CMD_READ: begin
						state_nxt     = i2cc_pkg::CTL_BITS;
						tx_nxt        = {`I2CC_READ_FILL, cmd_nack};
						bits_nxt      = `I2CC_ACK_BITS;
						leg_frame_nxt = 1'b0;
						first_nxt     = 1'b0;
					end
					default: begin
						if (cmd_legacy && !armed_r) begin
							refused_nxt = 1'b1;
						end else begin
							state_nxt     = i2cc_pkg::CTL_BITS;
							leg_frame_nxt = cmd_legacy;
							leg_en_nxt    = leg_en_r | cmd_legacy;
							tx_nxt        = {cmd_data, 1'b1};
							bits_nxt      = cmd_legacy ? `I2CC_BYTE_BITS : `I2CC_ACK_BITS;
							first_nxt     = 1'b0;
							if (first_r && !cmd_legacy && cmd_data[7:1] == `I2CC_LEGACY_ADDR) begin
								armed_nxt = 1'b1;
							end
						end
					end
				endcase
			end
		end else begin
			qcnt_nxt = (tick || (phase_r == 2'h2 && !scl_s_r)) ? 32'h0 : 32'(qcnt_r + 32'h1);
			if (go) begin
				phase_nxt = 2'(phase_r + 2'h1);
				case (state_r)
					i2cc_pkg::CTL_START: begin
						case (phase_r)
							2'h0: sda_oe_nxt = 1'b0;
							2'h1: scl_oe_nxt = 1'b0;
							2'h2: sda_oe_nxt = 1'b1;
							default: begin
								scl_oe_nxt = 1'b1;
								first_nxt  = 1'b1;
								state_nxt  = i2cc_pkg::CTL_IDLE;
							end
						endcase
					end
					i2cc_pkg::CTL_STOP: begin
						case (phase_r)
							2'h0: sda_oe_nxt = 1'b1;
							2'h1: scl_oe_nxt = 1'b0;
							2'h2: begin
								sda_oe_nxt = 1'b0;
								leg_en_nxt = 1'b0;
								armed_nxt  = 1'b0;
							end
							default: state_nxt = i2cc_pkg::CTL_IDLE;
						endcase
					end
					default: begin
						case (phase_r)
							2'h0: sda_oe_nxt = ~tx_r[8];
							2'h1: scl_oe_nxt = 1'b0;
							2'h2: rx_nxt = {rx_r[7:0], sda_s_r};
							default: begin
								scl_oe_nxt = 1'b1;
								tx_nxt     = {tx_r[7:0], 1'b1};
								bits_nxt   = 4'(bits_r - 4'h1);
								if (bits_r == 4'h1) begin
									sda_oe_nxt    = 1'b0;
									state_nxt     = i2cc_pkg::CTL_IDLE;
									rsp_valid_nxt = 1'b1;
									rsp_data_nxt  = leg_frame_r ? rx_r[7:0] : rx_r[8:1];
									rsp_nack_nxt  = leg_frame_r ? 1'b0 : rx_r[0];
								end
							end
						endcase
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r     <= i2cc_pkg::CTL_IDLE;
			phase_r     <= 2'h0;
			qcnt_r      <= 32'h0;
			bits_r      <= 4'h0;
			tx_r        <= 9'h1FF;
			rx_r        <= 9'h000;
			scl_oe_r    <= 1'b0;
			sda_oe_r    <= 1'b0;
			first_r     <= 1'b0;
			armed_r     <= 1'b0;
			leg_en_r    <= 1'b0;
			leg_frame_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 8'h00;
			rsp_nack_r  <= 1'b0;
			refused_r   <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			phase_r     <= phase_nxt;
			qcnt_r      <= qcnt_nxt;
			bits_r      <= bits_nxt;
			tx_r        <= tx_nxt;
			rx_r        <= rx_nxt;
			scl_oe_r    <= scl_oe_nxt;
			sda_oe_r    <= sda_oe_nxt;
			first_r     <= first_nxt;
			armed_r     <= armed_nxt;
			leg_en_r    <= leg_en_nxt;
			leg_frame_r <= leg_frame_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_data_r  <= rsp_data_nxt;
			rsp_nack_r  <= rsp_nack_nxt;
			refused_r   <= refused_nxt;
		end
	end

	assign bus.ctl_scl_o          = 1'b0;
	assign bus.ctl_scl_oe         = scl_oe_r;
	assign bus.ctl_sda_o          = 1'b0;
	assign bus.ctl_sda_oe         = sda_oe_r;
	assign bus.legacy_data_enable = leg_en_r;
	assign rsp_valid              = rsp_valid_r;
	assign rsp_data               = rsp_data_r;
	assign rsp_nack               = rsp_nack_r;
	assign cmd_refused            = refused_r;
endmodule : i2cc_controller
`default_nettype wire

// [i2cc_props.sv]
// Bus-side assertions for the two-wire link joining controller and target
`default_nettype none
module i2cc_props #(
	parameter int STRETCH_CYC = 1000,
	parameter int TIMEOUT_CYC = 2000
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Target configuration and local side
	input wire logic smbus_mode,
	input wire logic busy,
	// Resolved wires, target drivers and the controller's legacy enable
	input wire logic scl,
	input wire logic sda,
	input wire logic tgt_scl_oe,
	input wire logic tgt_sda_oe,
	input wire logic legacy_data_enable
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        scl_q_r, scl_q_nxt, sda_q_r, sda_q_nxt, frame_r, frame_nxt, start_w, stop_w;
	logic [3:0]  bits_r, bits_nxt;
	logic [31:0] hold_r, hold_nxt, age_r, age_nxt;

	// Wire START/STOP, clock rises since START, stretch length, transfer age
	always_comb begin
		start_w   = scl && scl_q_r && sda_q_r && !sda;
		stop_w    = scl && scl_q_r && !sda_q_r && sda;
		scl_q_nxt = scl;
		sda_q_nxt = sda;
		frame_nxt = start_w || (frame_r && !stop_w);
		bits_nxt  = start_w ? 4'h0 : ((scl && !scl_q_r && bits_r != 4'hF) ? bits_r + 4'h1 : bits_r);
		hold_nxt  = tgt_scl_oe ? hold_r + 32'h1 : 32'h0;
		age_nxt   = frame_nxt ? age_r + 32'h1 : 32'h0;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			frame_r <= 1'b0;
			bits_r  <= 4'h0;
			hold_r  <= 32'h0;
			age_r   <= 32'h0;
		end else begin
			scl_q_r <= scl_q_nxt;
			sda_q_r <= sda_q_nxt;
			frame_r <= frame_nxt;
			bits_r  <= bits_nxt;
			hold_r  <= hold_nxt;
			age_r   <= age_nxt;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_stop;
		stop_w;
	endsequence
	sequence s_released4;
		(!tgt_sda_oe && !tgt_scl_oe) [*4];
	endsequence

	property p_legacy_sda; legacy_data_enable |-> !tgt_sda_oe; endproperty
	property p_legacy_scl; legacy_data_enable |-> !tgt_scl_oe; endproperty
	property p_lde_after_addr; $rose(legacy_data_enable) |-> frame_r && bits_r >= 4'h9; endproperty
	property p_lde_drop_stop; s_stop |-> ##[0:2] !legacy_data_enable; endproperty
	property p_idle_after_stop; s_stop |=> s_released4; endproperty
	property p_stretch_limit; smbus_mode && tgt_scl_oe |-> hold_r <= 32'(STRETCH_CYC + 4); endproperty
	property p_age_timeout; smbus_mode && age_r >= 32'(TIMEOUT_CYC + 6) |-> !tgt_sda_oe && !tgt_scl_oe; endproperty
	property p_plain_hold; !smbus_mode && busy && tgt_scl_oe |=> tgt_scl_oe; endproperty
	property p_release_busy; tgt_scl_oe && !busy |-> ##[0:3] !tgt_scl_oe; endproperty

	a_legacy_sda: assert property (p_legacy_sda) else $error("target drove SDA in legacy frame");
	a_legacy_scl: assert property (p_legacy_scl) else $error("target held SCL in legacy frame");
	a_lde_after_addr: assert property (p_lde_after_addr) else $error("legacy enable before address");
	a_lde_drop_stop: assert property (p_lde_drop_stop) else $error("legacy enable kept after STOP");
	a_idle_after_stop: assert property (p_idle_after_stop) else $error("target active after STOP");
	a_stretch_limit: assert property (p_stretch_limit) else $error("management stretch too long");
	a_age_timeout: assert property (p_age_timeout) else $error("lines held after timeout");
	a_plain_hold: assert property (p_plain_hold) else $error("plain stretch dropped while busy");
	a_release_busy: assert property (p_release_busy) else $error("stretch kept after busy low");
endmodule : i2cc_props
`default_nettype wire

// [i2cc_tb_top.sv]
// Self-checking bench: controller and target joined over the two-wire interface
`default_nettype none
module i2cc_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int         STRETCH_CYC = 1000;
	localparam int         TIMEOUT_CYC = 27000;
	localparam logic [6:0] OWN_ADDR    = 7'h2A;

	logic                core_clk    = 1'b0;
	logic                rst         = 1'b1;
	logic                smbus_mode  = 1'b0;
	logic                busy        = 1'b0;
	logic                timeout_clr = 1'b0;
	logic                cmd_valid   = 1'b0;
	logic                cmd_legacy  = 1'b0;
	logic [7:0]          cmd_data    = 8'h00;
	i2cc_pkg::i2cc_cmd_t cmd         = i2cc_pkg::I2CC_CMD_START;
	logic                cmd_ready, rsp_valid, rsp_nack, cmd_refused, rx_valid, timeout_flag;
	logic [7:0]          rsp_data, rx_data;
	logic                scl_prev    = 1'b1;
	logic                rx_seen     = 1'b0;
	logic                ref_seen    = 1'b0;
	logic [3:0]          wire_cnt    = 4'h0;
	logic [8:0]          wire_bits   = 9'h000;
	logic [7:0]          rx_byte     = 8'h00;
	int                  fails       = 0;
	int                  checks_done = 0;

	always #2 core_clk = ~core_clk;

	i2cc_bus_if i_i2cc_bus_if ();
	i2cc_target #(.TIMEOUT_CYC(TIMEOUT_CYC), .STRETCH_CYC(STRETCH_CYC)) i_i2cc_target (
		.core_clk(core_clk), .rst(rst), .bus(i_i2cc_bus_if.tgt), .own_addr(OWN_ADDR), .smbus_mode(smbus_mode),
		.busy(busy), .tx_data(8'h00), .tx_taken(), .rx_data(rx_data), .rx_valid(rx_valid),
		.timeout_clr(timeout_clr), .timeout_flag(timeout_flag)
	);
	i2cc_controller i_i2cc_controller (
		.core_clk(core_clk), .rst(rst), .bus(i_i2cc_bus_if.ctl), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd(cmd), .cmd_data(cmd_data), .cmd_nack(1'b0), .cmd_legacy(cmd_legacy), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_nack(rsp_nack), .cmd_refused(cmd_refused)
	);
	i2cc_props #(.STRETCH_CYC(STRETCH_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) i_i2cc_props (
		.core_clk(core_clk), .rst(rst), .smbus_mode(smbus_mode), .busy(busy), .scl(i_i2cc_bus_if.scl),
		.sda(i_i2cc_bus_if.sda), .tgt_scl_oe(i_i2cc_bus_if.tgt_scl_oe), .tgt_sda_oe(i_i2cc_bus_if.tgt_sda_oe),
		.legacy_data_enable(i_i2cc_bus_if.legacy_data_enable)
	);

	// Shift SDA in at each SCL rise; latch local pulses
	always @(posedge core_clk) begin
		scl_prev <= i_i2cc_bus_if.scl;
		if (i_i2cc_bus_if.scl === 1'b1 && scl_prev === 1'b0) begin
			wire_bits <= {wire_bits[7:0], i_i2cc_bus_if.sda};
			wire_cnt  <= wire_cnt + 4'h1;
		end
		if (rx_valid === 1'b1) begin
			rx_seen <= 1'b1;
			rx_byte <= rx_data;
		end
		if (cmd_refused === 1'b1) ref_seen <= 1'b1;
	end

	task automatic report_and_stop();
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	task automatic wait_ready();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 60000) begin
			n++;
			tick(1);
		end
		if (n == 60000) begin
			fails++;
			report_and_stop();
		end
	endtask : wait_ready

	task automatic issue(input i2cc_pkg::i2cc_cmd_t c, input logic [7:0] d, input logic leg);
		wait_ready();
		cmd        = c;
		cmd_data   = d;
		cmd_legacy = leg;
		cmd_valid  = 1'b1;
		tick(1);
		cmd_valid  = 1'b0;
		cmd_legacy = 1'b0;
	endtask : issue

	task automatic run(input i2cc_pkg::i2cc_cmd_t c, input logic [7:0] d = 8'h00, input logic leg = 1'b0);
		issue(c, d, leg);
		wait_ready();
		tick(2);
	endtask : run

	// Read-direction legacy address, one legacy byte, STOP, then a legacy write that must be refused
	task automatic legacy_frame();
		rx_seen = 1'b0;
		run(i2cc_pkg::I2CC_CMD_START);
		wire_cnt = 4'h0;
		run(i2cc_pkg::I2CC_CMD_WRITE, 8'h03);
		chk_val({5'h00, wire_cnt}, 9'h009);
		chk_val(wire_bits, 9'h007);
		chk_bit(rsp_nack, 1'b1);
		chk_val({1'b0, rsp_data}, 9'h003);
		wire_cnt = 4'h0;
		run(i2cc_pkg::I2CC_CMD_WRITE, 8'hC3, 1'b1);
		chk_bit(i_i2cc_bus_if.legacy_data_enable, 1'b1);
		chk_val({5'h00, wire_cnt}, 9'h008);
		chk_val({1'b0, wire_bits[7:0]}, 9'h0C3);
		chk_bit(rsp_nack, 1'b0);
		chk_val({1'b0, rsp_data}, 9'h0C3);
		chk_bit(rx_seen, 1'b0);
		run(i2cc_pkg::I2CC_CMD_STOP);
		chk_bit(i_i2cc_bus_if.legacy_data_enable, 1'b0);
		ref_seen = 1'b0;
		wire_cnt = 4'h0;
		run(i2cc_pkg::I2CC_CMD_WRITE, 8'h5A, 1'b1);
		chk_bit(ref_seen, 1'b1);
		chk_val({5'h00, wire_cnt}, 9'h000);
		chk_bit(i_i2cc_bus_if.legacy_data_enable, 1'b0);
	endtask : legacy_frame

	// Plain mode: stretch well past the management limit, then the data byte still lands
	task automatic plain_stretch();
		smbus_mode = 1'b0;
		busy       = 1'b1;
		rx_seen    = 1'b0;
		run(i2cc_pkg::I2CC_CMD_START);
		run(i2cc_pkg::I2CC_CMD_WRITE, {OWN_ADDR, 1'b0});
		chk_bit(rsp_nack, 1'b0);
		issue(i2cc_pkg::I2CC_CMD_WRITE, 8'h96, 1'b0);
		tick(3 * STRETCH_CYC);
		chk_bit(i_i2cc_bus_if.tgt_scl_oe, 1'b1);
		chk_bit(i_i2cc_bus_if.scl, 1'b0);
		busy = 1'b0;
		wait_ready();
		tick(2);
		chk_bit(rx_seen, 1'b1);
		chk_val({1'b0, rx_byte}, 9'h096);
		chk_bit(timeout_flag, 1'b0);
		run(i2cc_pkg::I2CC_CMD_STOP);
	endtask : plain_stretch

	// Management mode: stretch released in time, transfer age forces reset, sticky flag cleared locally
	task automatic smbus_timeout();
		int n;
		smbus_mode = 1'b1;
		busy       = 1'b1;
		run(i2cc_pkg::I2CC_CMD_START);
		run(i2cc_pkg::I2CC_CMD_WRITE, {OWN_ADDR, 1'b0});
		chk_bit(rsp_nack, 1'b0);
		tick(STRETCH_CYC + 20);
		chk_bit(i_i2cc_bus_if.tgt_scl_oe, 1'b0);
		chk_bit(timeout_flag, 1'b0);
		n = 0;
		while (timeout_flag !== 1'b1 && n < TIMEOUT_CYC) begin
			n++;
			tick(1);
		end
		if (n == TIMEOUT_CYC) begin
			fails++;
			report_and_stop();
		end
		chk_bit(i_i2cc_bus_if.tgt_sda_oe, 1'b0);
		chk_bit(i_i2cc_bus_if.tgt_scl_oe, 1'b0);
		tick(20);
		chk_bit(timeout_flag, 1'b1);
		timeout_clr = 1'b1;
		tick(1);
		timeout_clr = 1'b0;
		tick(1);
		chk_bit(timeout_flag, 1'b0);
		busy = 1'b0;
		run(i2cc_pkg::I2CC_CMD_STOP);
		smbus_mode = 1'b0;
	endtask : smbus_timeout

	initial begin
		tick(4);
		rst = 1'b0;
		tick(2);
		legacy_frame();
		plain_stretch();
		smbus_timeout();
		report_and_stop();
	end
endmodule : i2cc_tb_top
`default_nettype wire
